// File: logic/bcs_scaler_pkg.sv
// Purpose: Shared constants and types for the video BCS and scaler front end.
// Assumes: 8-bit samples, 4:2:2 pixel stream on the expansion port.
// Notes: Register offsets are word indices; byte address is four times the index.
package bcs_scaler_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_PORT_CTRL = 8'h0E;
	localparam logic [ADDR_W-1:0] REG_STATUS_CTRL = 8'h0D;
	localparam logic [ADDR_W-1:0] REG_FILTER_CTRL = 8'h28;
	localparam logic [ADDR_W-1:0] REG_OPTION_CTRL = 8'h30;
	localparam logic [ADDR_W-1:0] REG_LUMA_OFFSET = 8'h40;
	localparam logic [ADDR_W-1:0] REG_LUMA_GAIN = 8'h41;
	localparam logic [ADDR_W-1:0] REG_CHROMA_GAIN = 8'h42;
	localparam logic [ADDR_W-1:0] REG_CHROMA_PHASE = 8'h43;
	localparam logic [ADDR_W-1:0] REG_SIZE_X = 8'h44;
	localparam logic [ADDR_W-1:0] REG_SIZE_Y = 8'h45;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h46;
	localparam logic [7:0] OFFSET_RESET = 8'h80;
	localparam logic [6:0] GAIN_RESET = 7'h40;
	localparam logic [7:0] CLIP_MIN = 8'h01;
	localparam logic [7:0] CLIP_MAX = 8'hFE;
	localparam int GAIN_SHIFT = 6;
	localparam int SAT_TOP = 10'sd254;
	localparam int SAT_BOT = 10'sd1;
	localparam logic [3:0] RATIO_DEN = 4'hF;
	localparam logic [3:0] H_BOUND1 = 4'hE;
	localparam logic [3:0] H_BOUND6 = 4'hB;
	localparam logic [3:0] H_BOUND3 = 4'h7;
	localparam logic [3:0] H_BOUND4 = 4'h3;
	localparam logic [3:0] V_BOUND1 = 4'hD;
	localparam logic [3:0] V_BOUND2 = 4'h4;
	localparam int RT_FRAME_BITS = 16;
	typedef enum logic [2:0] {HF_BYPASS, HF_TAP2, HF_TAP3, HF_TAP4, HF_TAP5, HF_TAP9} hresp_t;
	typedef enum logic [1:0] {VF_BYPASS, VF_FUNC1, VF_FUNC2, VF_FUNC3} vresp_t;
	typedef struct packed {
		logic [7:0] luma;
		logic [7:0] chroma;
	} pix_t;
	typedef struct packed {
		logic pixelEn;
		logic syncEn;
		logic clockEn;
	} drive_t;
endpackage

// File: logic/bcs_scaler_front_end.sv
// Purpose: Brightness/contrast/saturation, expansion port direction, status pins,
//  real-time serial output and horizontal/vertical filter selection.
// Assumes: Pins and the link clock arrive asynchronously and are synchronised.
// Notes: Filters are simple luma box averages; horizontal length follows the response, vertical is a two-line mean.
`timescale 1ns/100ps
module bcs_scaler_front_end
	import bcs_scaler_pkg::*;
#(
	parameter int LINE_LEN = 384,
	parameter int RT_DIV = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire pix_t decPixel,
	input wire logic decValid,
	input wire logic decLineRef,
	input wire logic decFieldSync,
	input wire logic decLineClock,
	input wire logic decClockQual,
	input wire logic decFieldOdd,
	input wire logic decSeqBit,
	input wire logic decHLock,
	input wire logic decVDetect,
	input wire logic [23:0] decRtWord,
	input wire logic dirPin,
	input wire pix_t portPixelIn,
	input wire logic lineValidRefIn,
	input wire logic fieldSyncIn,
	input wire logic lineClockIn,
	input wire logic clockQualifierIn,
	output pix_t portPixelOut,
	output logic portPixelOe,
	output logic lineValidRefOut,
	output logic fieldSyncOut,
	output logic syncOe,
	output logic lineClockOut,
	output logic clockQualifierOut,
	output logic clockOe,
	output logic statusOutA,
	output logic statusOutB,
	output logic realtimeSerialOut,
	output logic [7:0] lumaOut,
	output logic [7:0] uOut,
	output logic [7:0] vOut,
	output logic chromaKey,
	output logic outValid,
	output logic [1:0] portMode
);
	logic [7:0] lumaOffsetCode_q;
	logic [6:0] lumaGainCode_q;
	logic [6:0] chromaGainCode_q;
	logic [7:0] chromaPhaseCode_q;
	drive_t drive_q;
	logic statusOutSelect_q;
	logic [2:0] hfilterSelect_q;
	logic vfilterSelectHi_q;
	logic vfilterSelectLo_q;
	logic adaptiveFilterEnable_q;
	logic adaptiveVerticalOption_q;
	logic [9:0] destWidth_q;
	logic [9:0] sourceWidth_q;
	logic [9:0] destHeight_q;
	logic [9:0] sourceHeight_q;
	logic [1:0] dirSync_q;
	logic [1:0] lclkSync_q;
	logic lclkPrev_q;
	pix_t pixS1_q;
	pix_t pixS2_q;
	logic [1:0] lrefSync_q;
	logic [1:0] fsyncSync_q;
	logic [1:0] mode_d;
	hresp_t hResp;
	vresp_t vResp;
	// Manual select code table, index is the 3-bit field
	localparam hresp_t H_TABLE [8] = '{HF_BYPASS, HF_TAP2, HF_TAP3, HF_TAP4, HF_TAP5,
		HF_TAP9, HF_TAP9, HF_TAP9};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lumaOffsetCode_q <= OFFSET_RESET;
			lumaGainCode_q <= GAIN_RESET;
			chromaGainCode_q <= GAIN_RESET;
			chromaPhaseCode_q <= 8'h00;
			drive_q <= '{pixelEn: 1'b1, syncEn: 1'b1, clockEn: 1'b1};
			statusOutSelect_q <= 1'b0;
			hfilterSelect_q <= 3'h0;
			vfilterSelectHi_q <= 1'b0;
			vfilterSelectLo_q <= 1'b0;
			adaptiveFilterEnable_q <= 1'b0;
			adaptiveVerticalOption_q <= 1'b0;
			destWidth_q <= 10'h000;
			sourceWidth_q <= 10'h000;
			destHeight_q <= 10'h000;
			sourceHeight_q <= 10'h000;
		end else if (regWr) begin
			case (regAddr)
				REG_PORT_CTRL: drive_q <= regWdata[2:0];
				REG_STATUS_CTRL: statusOutSelect_q <= regWdata[0];
				REG_FILTER_CTRL: begin
					hfilterSelect_q <= regWdata[2:0];
					vfilterSelectLo_q <= regWdata[3];
					vfilterSelectHi_q <= regWdata[4];
					adaptiveFilterEnable_q <= regWdata[5];
				end
				REG_OPTION_CTRL: adaptiveVerticalOption_q <= regWdata[0];
				REG_LUMA_OFFSET: lumaOffsetCode_q <= regWdata[7:0];
				REG_LUMA_GAIN: lumaGainCode_q <= regWdata[6:0];
				REG_CHROMA_GAIN: chromaGainCode_q <= regWdata[6:0];
				REG_CHROMA_PHASE: chromaPhaseCode_q <= regWdata[7:0];
				REG_SIZE_X: begin
					destWidth_q <= regWdata[9:0];
					sourceWidth_q <= regWdata[25:16];
				end
				REG_SIZE_Y: begin
					destHeight_q <= regWdata[9:0];
					sourceHeight_q <= regWdata[25:16];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 32'h0000_0000;
		end else if (regRd) begin
			case (regAddr)
				REG_PORT_CTRL: regRdata <= {29'h0, drive_q};
				REG_STATUS_CTRL: regRdata <= {31'h0, statusOutSelect_q};
				REG_FILTER_CTRL: regRdata <= {26'h0, adaptiveFilterEnable_q, vfilterSelectHi_q,
					vfilterSelectLo_q, hfilterSelect_q};
				REG_OPTION_CTRL: regRdata <= {31'h0, adaptiveVerticalOption_q};
				REG_LUMA_OFFSET: regRdata <= {24'h0, lumaOffsetCode_q};
				REG_LUMA_GAIN: regRdata <= {25'h0, lumaGainCode_q};
				REG_CHROMA_GAIN: regRdata <= {25'h0, chromaGainCode_q};
				REG_CHROMA_PHASE: regRdata <= {24'h0, chromaPhaseCode_q};
				REG_SIZE_X: regRdata <= {6'h0, sourceWidth_q, 6'h0, destWidth_q};
				REG_SIZE_Y: regRdata <= {6'h0, sourceHeight_q, 6'h0, destHeight_q};
				REG_STATUS: regRdata <= {24'h0, 1'b0, vResp, hResp, portMode};
				default: regRdata <= 32'h0000_0000;
			endcase
		end else begin
			regRdata <= 32'h0000_0000;
		end
	end

	// Pin synchronisers; first stage only feeds the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dirSync_q <= 2'b00;
			lclkSync_q <= 2'b00;
			lclkPrev_q <= 1'b0;
			lrefSync_q <= 2'b00;
			fsyncSync_q <= 2'b00;
			pixS1_q <= '0;
			pixS2_q <= '0;
		end else begin
			dirSync_q <= {dirSync_q[0], dirPin};
			lclkSync_q <= {lclkSync_q[0], lineClockIn};
			lclkPrev_q <= lclkSync_q[1];
			lrefSync_q <= {lrefSync_q[0], lineValidRefIn};
			fsyncSync_q <= {fsyncSync_q[0], fieldSyncIn};
			pixS1_q <= portPixelIn;
			pixS2_q <= pixS1_q;
		end
	end

	always_comb begin
		if (!dirSync_q[1] && drive_q.pixelEn && drive_q.syncEn && drive_q.clockEn) begin
			mode_d = 2'd0;
		end else if (dirSync_q[1] && drive_q.syncEn && drive_q.clockEn) begin
			mode_d = 2'd1;
		end else if (dirSync_q[1] && !drive_q.syncEn && !drive_q.clockEn) begin
			mode_d = 2'd2;
		end else if (dirSync_q[1] && !drive_q.syncEn && drive_q.clockEn) begin
			mode_d = 2'd3;
		end else begin
			mode_d = 2'd0;
		end
	end

	// Port drivers; enables follow the decoded mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			portMode <= 2'd0;
			portPixelOe <= 1'b0;
			syncOe <= 1'b0;
			clockOe <= 1'b0;
			portPixelOut <= '0;
			lineValidRefOut <= 1'b0;
			fieldSyncOut <= 1'b0;
			lineClockOut <= 1'b0;
			clockQualifierOut <= 1'b0;
		end else begin
			portMode <= mode_d;
			portPixelOe <= (mode_d == 2'd0) && drive_q.pixelEn;
			syncOe <= (mode_d == 2'd0 || mode_d == 2'd1) && drive_q.syncEn;
			clockOe <= (mode_d != 2'd2) && drive_q.clockEn;
			portPixelOut <= decPixel;
			lineValidRefOut <= decLineRef;
			fieldSyncOut <= decFieldSync;
			lineClockOut <= decLineClock;
			clockQualifierOut <= decClockQual;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			statusOutA <= 1'b0;
			statusOutB <= 1'b0;
		end else if (statusOutSelect_q) begin
			statusOutA <= decHLock;
			statusOutB <= decVDetect;
		end else begin
			statusOutA <= decFieldOdd;
			statusOutB <= ~decSeqBit;
		end
	end

	// Serial real-time word, MSB first, start bit then 24 data bits
	logic [7:0] rtDiv_q;
	logic [4:0] rtBit_q;
	logic [23:0] rtShift_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rtDiv_q <= 8'h00;
			rtBit_q <= 5'h00;
			rtShift_q <= 24'h000000;
			realtimeSerialOut <= 1'b0;
		end else if (rtDiv_q == 8'(RT_DIV - 1)) begin
			rtDiv_q <= 8'h00;
			if (rtBit_q == 5'h00) begin
				rtShift_q <= decRtWord;
				realtimeSerialOut <= 1'b1;
				rtBit_q <= 5'h18;
			end else begin
				realtimeSerialOut <= rtShift_q[23];
				rtShift_q <= {rtShift_q[22:0], 1'b0};
				rtBit_q <= rtBit_q - 5'h01;
			end
		end else begin
			rtDiv_q <= rtDiv_q + 8'h01;
		end
	end

	// Adaptive choice; tightest bound checked first, 15*d <= k*s
	function automatic logic le(input logic [9:0] d, input logic [9:0] s, input logic [3:0] k);
		le = (14'(d) * 14'(RATIO_DEN)) <= (14'(s) * 14'(k));
	endfunction

	always_comb begin
		if (adaptiveFilterEnable_q) begin
			if (le(destWidth_q, sourceWidth_q, H_BOUND4)) hResp = HF_TAP9;
			else if (le(destWidth_q, sourceWidth_q, H_BOUND3)) hResp = HF_TAP5;
			else if (le(destWidth_q, sourceWidth_q, H_BOUND6)) hResp = HF_TAP4;
			else if (le(destWidth_q, sourceWidth_q, H_BOUND1)) hResp = HF_TAP2;
			else hResp = HF_BYPASS;
			if (le(destHeight_q, sourceHeight_q, V_BOUND2)) vResp = VF_FUNC2;
			else if (le(destHeight_q, sourceHeight_q, V_BOUND1)) vResp = VF_FUNC1;
			else vResp = VF_BYPASS;
			if (adaptiveVerticalOption_q && vResp == VF_FUNC2) vResp = VF_FUNC3;
		end else begin
			hResp = H_TABLE[hfilterSelect_q];
			vResp = vresp_t'({vfilterSelectHi_q, vfilterSelectLo_q});
		end
	end

	// Source select: internal decoder or external port
	pix_t src;
	logic srcValid;
	logic srcLine;
	logic extPix;
	assign extPix = (portMode != 2'd0);
	assign src = extPix ? pixS2_q : decPixel;
	assign srcValid = extPix ? (lclkSync_q[1] && !lclkPrev_q) : decValid;
	assign srcLine = (portMode == 2'd2 || portMode == 2'd3) ? lrefSync_q[1] : decLineRef;

	// BCS arithmetic, gain = code/64, offset centred on 80H
	logic signed [17:0] lumaAdj;
	logic signed [17:0] chromaAdj;
	logic signed [17:0] chromaDiff;
	logic [7:0] lumaClip;
	logic [7:0] chromaClip;
	always_comb begin
		// Signed difference, so scaling a low U or V keeps its sign
		chromaDiff = $signed({10'h000, src.chroma}) - 18'sd128;
		lumaAdj = 18'((18'(src.luma) * 18'(lumaGainCode_q)) >>> GAIN_SHIFT)
			+ 18'(lumaOffsetCode_q) - 18'(OFFSET_RESET);
		chromaAdj = 18'((chromaDiff * $signed({11'h000, chromaGainCode_q})) >>> GAIN_SHIFT)
			+ 18'sd128;
		lumaClip = (lumaAdj > 18'(SAT_TOP)) ? CLIP_MAX :
			(lumaAdj < 18'(SAT_BOT)) ? CLIP_MIN : lumaAdj[7:0];
		chromaClip = (chromaAdj > 18'(SAT_TOP)) ? CLIP_MAX :
			(chromaAdj < 18'(SAT_BOT)) ? CLIP_MIN : chromaAdj[7:0];
	end

	// Horizontal box filter on the luma path only; chroma taps are shifted but unused
	logic [7:0] yTap_q [8];
	logic [7:0] cTap_q [8];
	logic phase_q;
	logic [7:0] uHold_q;
	logic [11:0] ySum;
	logic [3:0] taps;
	always_comb begin
		case (hResp)
			HF_TAP2: taps = 4'd2;
			HF_TAP3: taps = 4'd4;
			HF_TAP4: taps = 4'd4;
			HF_TAP5: taps = 4'd8;
			HF_TAP9: taps = 4'd8;
			default: taps = 4'd1;
		endcase
		ySum = 12'(lumaClip);
		for (int i = 0; i < 7; i++) begin
			if (4'(i + 1) < taps) ySum = ySum + 12'(yTap_q[i]);
		end
	end

	// Vertical luma line store and blend
	logic [7:0] lineMem [LINE_LEN];
	logic [8:0] xPos_q;
	logic [7:0] yH;
	logic [7:0] yV;
	logic [7:0] above;
	assign yH = (taps == 4'd8) ? ySum[10:3] : (taps == 4'd4) ? ySum[9:2] :
		(taps == 4'd2) ? ySum[8:1] : ySum[7:0];
	assign above = lineMem[xPos_q];
	assign yV = (vResp == VF_BYPASS) ? yH : 8'((9'(yH) + 9'(above)) >> 1);
	always_ff @(posedge sys_clk) begin
		if (srcValid) lineMem[xPos_q] <= yH;
	end

	// Pixel dropping accumulator ahead of output
	logic [10:0] dda_q;
	logic keep;
	assign keep = (dda_q + 11'(destWidth_q)) >= 11'(sourceWidth_q);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				yTap_q[i] <= 8'h00;
				cTap_q[i] <= 8'h00;
			end
			phase_q <= 1'b0;
			uHold_q <= 8'h80;
			xPos_q <= 9'h000;
			dda_q <= 11'h000;
			lumaOut <= 8'h00;
			uOut <= 8'h80;
			vOut <= 8'h80;
			chromaKey <= 1'b0;
			outValid <= 1'b0;
		end else begin
			outValid <= 1'b0;
			if (!srcLine) begin
				phase_q <= 1'b0;
				xPos_q <= 9'h000;
				dda_q <= 11'h000;
			end else if (srcValid) begin
				yTap_q[0] <= lumaClip;
				cTap_q[0] <= chromaClip;
				for (int i = 1; i < 8; i++) begin
					yTap_q[i] <= yTap_q[i-1];
					cTap_q[i] <= cTap_q[i-1];
				end
				phase_q <= ~phase_q;
				xPos_q <= (xPos_q == 9'(LINE_LEN - 1)) ? 9'h000 : xPos_q + 9'h001;
				if (!phase_q) uHold_q <= chromaClip;
				dda_q <= keep ? 11'(dda_q + 11'(destWidth_q) - 11'(sourceWidth_q))
					: 11'(dda_q + 11'(destWidth_q));
				if (phase_q && keep) begin
					lumaOut <= yV;
					uOut <= uHold_q;
					vOut <= chromaClip;
					chromaKey <= (uHold_q != 8'h80) || (chromaClip != 8'h80);
					outValid <= 1'b1;
				end
			end
		end
	end
endmodule

// File: dv/bcs_scaler_front_end_props.sv
// Purpose: Port-level checks for the BCS front end.
// Assumes: One clock domain, async active-low reset.
// Notes: Attached by bind.
`timescale 1ns/100ps
module bcs_scaler_front_end_props
	import bcs_scaler_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic [1:0] portMode,
	input wire logic portPixelOe,
	input wire logic syncOe,
	input wire logic clockOe,
	input wire logic [7:0] lumaOut,
	input wire logic [7:0] uOut,
	input wire logic [7:0] vOut,
	input wire logic chromaKey,
	input wire logic outValid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_mode0_drive: assert property ($past(rst_n) && portMode == 2'h0 |-> portPixelOe && syncOe && clockOe)
		else $error("mode 0 drive enables wrong");
	a_mode1_drive: assert property (portMode == 2'h1 |-> !portPixelOe && syncOe && clockOe)
		else $error("mode 1 drive enables wrong");
	a_mode2_drive: assert property (portMode == 2'h2 |-> !(portPixelOe || syncOe || clockOe))
		else $error("mode 2 drive enables wrong");
	a_mode3_drive: assert property (portMode == 2'h3 |-> !portPixelOe && !syncOe && clockOe)
		else $error("mode 3 drive enables wrong");
	a_luma_clip: assert property (outValid |-> lumaOut inside {[8'h01:8'hFE]})
		else $error("luma outside clip range");
	a_chroma_clip: assert property (outValid |-> uOut inside {[8'h01:8'hFE]} && vOut inside {[8'h01:8'hFE]})
		else $error("chroma outside clip range");
	a_key_bit: assert property (outValid |-> chromaKey == (uOut != 8'h80 || vOut != 8'h80))
		else $error("chroma key bit wrong");
	a_read_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside read cycle");
endmodule
bind bcs_scaler_front_end bcs_scaler_front_end_props u_bcs_scaler_front_end_props (.sys_clk,
	.rst_n, .regRd, .regRdata, .portMode, .portPixelOe, .syncOe, .clockOe, .lumaOut, .uOut,
	.vOut, .chromaKey, .outValid);

// File: dv/video_source_model.sv
// Purpose: External 4:2:2 source on the expansion port.
// Assumes: Line clock of 80 ns, only while running.
// Notes: Idle lines show the inverse of the last pixel.
`timescale 1ns/100ps
module video_source_model
	import bcs_scaler_pkg::*;
(
	input wire logic run,
	input wire logic [7:0] yVal,
	input wire logic [7:0] uVal,
	input wire logic [7:0] vVal,
	output logic lineClk,
	output pix_t pixel,
	output logic lineRef
);
	initial begin
		lineClk = 1'h0;
		pixel = '0;
		lineRef = 1'h0;
	end
	// Whole U/V pairs, so a stop never splits a pair
	always begin
		wait (run);
		lineRef = 1'h1;
		pixel = '{yVal, uVal};
		#40 lineClk = 1'h1;
		#40 lineClk = 1'h0;
		pixel = '{yVal, vVal};
		#40 lineClk = 1'h1;
		#40 lineClk = 1'h0;
		if (!run) begin
			lineRef = 1'h0;
			pixel = ~pixel;
		end
	end
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the BCS front end.
// Assumes: 200 MHz clock, reset held 12 cycles.
// Notes: External source is exercised in mode 1 only.
`timescale 1ns/100ps
module testbench;
	import bcs_scaler_pkg::*;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic [31:0] regRdata;
	logic [31:0] rv;
	logic regWr = 1'h0;
	logic regRd = 1'h0;
	pix_t decPixel = '0;
	pix_t portPixelIn;
	logic decValid = 1'h0;
	logic decLineRef = 1'h0;
	logic decFieldOdd = 1'h0;
	logic decSeqBit = 1'h0;
	logic decHLock = 1'h0;
	logic decVDetect = 1'h0;
	logic dirPin = 1'h0;
	logic run = 1'h0;
	logic [7:0] yVal = 8'h60;
	logic [7:0] uVal = 8'h20;
	logic [7:0] vVal = 8'hE0;
	logic lineRefIn, lineClk, portPixelOe, syncOe, clockOe, statusOutA, statusOutB;
	logic chromaKey, outValid, realtimeSerialOut;
	logic [24:0] rtSeen;
	pix_t portPixelOut;
	logic [7:0] lumaOut, uOut, vOut;
	logic [1:0] portMode;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int i;
	logic [7:0] ra[6] = '{8'h0E, 8'h40, 8'h41, 8'h42, 8'h30, 8'h7F};
	logic [7:0] re[6] = '{8'h07, 8'h80, 8'h40, 8'h40, 8'h00, 8'h00};
	logic [3:0] hd[5] = '{4'hF, 4'hE, 4'hB, 4'h7, 4'h3};
	logic [2:0] he[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};

	bcs_scaler_front_end u_bcs_scaler_front_end (.sys_clk, .rst_n, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .decPixel, .decValid, .decLineRef, .decFieldSync(decVDetect),
		.decLineClock(lineClk), .decClockQual(decValid), .decFieldOdd, .decSeqBit, .decHLock,
		.decVDetect, .decRtWord(24'hA5C3F0), .dirPin, .portPixelIn, .lineValidRefIn(lineRefIn),
		.fieldSyncIn(1'h0), .lineClockIn(lineClk), .clockQualifierIn(1'h0), .portPixelOut,
		.portPixelOe, .lineValidRefOut(), .fieldSyncOut(), .syncOe, .lineClockOut(),
		.clockQualifierOut(), .clockOe, .statusOutA, .statusOutB, .realtimeSerialOut,
		.lumaOut, .uOut, .vOut, .chromaKey, .outValid, .portMode);
	video_source_model u_video_source_model (.run, .yVal, .uVal, .vVal, .lineClk,
		.pixel(portPixelIn), .lineRef(lineRefIn));

	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge sys_clk);
		regWr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge sys_clk);
		regRd <= 1'h0;
		#1 rv = regRdata;
	endtask
	task automatic waitOut(input logic [7:0] ey, input logic [7:0] eu, input logic [7:0] ev);
		int k;
		k = 0;
		// The pulse may already stand from the edge that called us
		#1;
		while (outValid !== 1'h1 && k < 400) begin
			@(posedge sys_clk);
			#1 k++;
		end
		chk("out valid", 32'h1, 32'(outValid));
		chk("luma", 32'(ey), 32'(lumaOut));
		chk("u", 32'(eu), 32'(uOut));
		chk("v", 32'(ev), 32'(vOut));
	endtask
	task automatic pair(input logic [7:0] o, g, c, y, u, v, ey, eu, ev);
		wr(REG_LUMA_OFFSET, 32'(o));
		wr(REG_LUMA_GAIN, 32'(g));
		wr(REG_CHROMA_GAIN, 32'(c));
		@(posedge sys_clk);
		decPixel <= '{y, u};
		decValid <= 1'h1;
		@(posedge sys_clk);
		decValid <= 1'h0;
		@(posedge sys_clk);
		decPixel <= '{y, v};
		decValid <= 1'h1;
		@(posedge sys_clk);
		decValid <= 1'h0;
		waitOut(ey, eu, ev);
		chk("port pixel", 32'({y, v}), 32'(portPixelOut));
	endtask
	task automatic mode(input logic [2:0] en, input logic dir, input logic [1:0] m,
		input logic [2:0] oe);
		wr(REG_PORT_CTRL, 32'(en));
		dirPin <= dir;
		repeat (8) @(posedge sys_clk);
		#1 chk("oe", 32'(oe), 32'({portPixelOe, syncOe, clockOe}));
		rd(REG_STATUS);
		chk("mode", 32'(m), 32'(rv[1:0]));
	endtask
	task automatic stat(input logic sel, odd, lock, vdet, ea, eb);
		wr(REG_STATUS_CTRL, 32'(sel));
		decFieldOdd <= odd;
		decHLock <= lock;
		decVDetect <= vdet;
		decSeqBit <= vdet;
		repeat (6) @(posedge sys_clk);
		#1 chk("status a", 32'(ea), 32'(statusOutA));
		chk("status b", 32'(eb), 32'(statusOutB));
	endtask

	// One serial frame from reset: start bit, then the word MSB first
	initial begin
		@(posedge rst_n);
		@(posedge realtimeSerialOut);
		for (int b = 24; b >= 0; b--) begin
			#1 rtSeen[b] = realtimeSerialOut;
			repeat (8) @(posedge sys_clk);
		end
		chk("serial frame", 32'h01A5_C3F0, 32'(rtSeen));
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'h1;
		for (i = 0; i < 6; i++) begin
			rd(ra[i]);
			chk("reset value", 32'(re[i]), rv);
		end
		wr(8'h7F, 32'hFF);
		rd(8'h7F);
		chk("unmapped", 32'h0, rv);
		mode(3'h7, 1'h0, 2'h0, 3'h7);
		mode(3'h7, 1'h1, 2'h1, 3'h3);
		mode(3'h0, 1'h1, 2'h2, 3'h0);
		mode(3'h1, 1'h1, 2'h3, 3'h1);
		mode(3'h7, 1'h0, 2'h0, 3'h7);
		decLineRef <= 1'h1;
		pair(8'h80, 8'h40, 8'h40, 8'h50, 8'h30, 8'hD0, 8'h50, 8'h30, 8'hD0);
		pair(8'h80, 8'h7F, 8'h7F, 8'hFF, 8'h00, 8'hFF, 8'hFE, 8'h01, 8'hFE);
		pair(8'h80, 8'h00, 8'h00, 8'h50, 8'h30, 8'hD0, 8'h01, 8'h80, 8'h80);
		pair(8'hFF, 8'h40, 8'h40, 8'h10, 8'h30, 8'hD0, 8'h8F, 8'h30, 8'hD0);
		pair(8'h00, 8'h40, 8'h40, 8'h10, 8'h30, 8'hD0, 8'h01, 8'h30, 8'hD0);
		// Mode 1 keeps the device's own line reference, so it stays high
		wr(REG_LUMA_OFFSET, 32'h80);
		dirPin <= 1'h1;
		run <= 1'h1;
		waitOut(8'h60, 8'h20, 8'hE0);
		run <= 1'h0;
		for (i = 0; i < 8; i++) begin
			wr(REG_FILTER_CTRL, 32'(i));
			rd(REG_STATUS);
			chk("manual h", (i > 4) ? 32'h5 : 32'(i), 32'(rv[4:2]));
		end
		wr(REG_FILTER_CTRL, 32'h20);
		wr(REG_SIZE_Y, 32'h000F000F);
		for (i = 0; i < 5; i++) begin
			wr(REG_SIZE_X, {28'h000F000, hd[i]});
			rd(REG_STATUS);
			chk("adaptive h", 32'(he[i]), 32'(rv[4:2]));
		end
		for (i = 0; i < 4; i++) begin
			wr(REG_OPTION_CTRL, 32'(i == 3));
			wr(REG_SIZE_Y, {28'h000F000, hd[0] - 4'(i == 1 ? 2 : (i > 1 ? 11 : 0))});
			rd(REG_STATUS);
			chk("adaptive v", 32'(i), 32'(rv[6:5]));
		end
		stat(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
		stat(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
		stat(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
		stat(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
		end_of_test();
	end
endmodule
